/* hdl/lcdh_host_port.sv */
// host command and data port of the dot-matrix display controller
`timescale 1ns/1ns
module lcdh_host_port (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic serial_clk,
   input wire logic parallel_serial_strap,
   input wire logic bus_style_strap,
   input wire logic chip_select_low_active_n,
   input wire logic chip_select_high_active,
   input wire logic data_command_select,
   input wire logic read_strobe_pin,
   input wire logic write_strobe_pin,
   input wire logic [7:0] data_in,
   output logic [7:0] data_out,
   output logic [7:0] data_oe,
   input wire logic [7:0] disp_rd_data,
   input wire logic [7:0] status_byte,
   output logic wr_valid,
   output lcdh_pkg::lcdh_xfer_t wr_xfer,
   output logic rd_valid,
   output logic rd_is_data
);

   ////////////////////////////////////////////////////////////////////////
   // serial clock domain

   lcdh_pkg::lcdh_ser_t ser_reg;
   lcdh_pkg::lcdh_ser_t ser_next;
   logic [2:0] bit_cnt_reg;
   logic ser_sel_n;
   logic ser_clr_n;

   // serial clock stops between frames, so the count is cleared by the
   // select pins themselves rather than waiting for another clock edge
   assign ser_sel_n = chip_select_low_active_n | ~chip_select_high_active;
   assign ser_clr_n = rst_n & ~ser_sel_n;

   always_ff @(posedge serial_clk or negedge ser_clr_n) begin
      if (!ser_clr_n) begin
         bit_cnt_reg <= lcdh_pkg::BIT_ZERO;
      end else if (!parallel_serial_strap) begin
         bit_cnt_reg <= bit_cnt_reg + lcdh_pkg::BIT_ONE;
      end
   end

   always_comb begin
      ser_next = ser_reg;
      if (ser_clr_n && !parallel_serial_strap) begin
         // only the serial data pin is read; the low seven are ignored
         ser_next.shift = {ser_reg.shift[6:0],
                           data_in[lcdh_pkg::SI_BIT]};
         if (bit_cnt_reg == lcdh_pkg::BIT_LAST) begin
            ser_next.byte_q = {ser_reg.shift[6:0],
                               data_in[lcdh_pkg::SI_BIT]};
            ser_next.a0 = data_command_select;
            ser_next.tog = ~ser_reg.tog;
         end
      end
   end

   always_ff @(posedge serial_clk or negedge rst_n) begin
      if (!rst_n) begin
         ser_reg <= '0;
      end else begin
         ser_reg <= ser_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // core clock domain

   lcdh_pkg::lcdh_core_t core_reg;
   lcdh_pkg::lcdh_core_t core_next;
   lcdh_pkg::lcdh_pins_t pins_raw;
   lcdh_pkg::lcdh_mode_t mode;
   logic cs_now;
   logic cs_prev;
   logic rd_active;
   logic wr_evt;
   logic rd_evt;
   logic ser_evt;

   assign pins_raw = '{cs_n: chip_select_low_active_n,
                       cs_hi: chip_select_high_active,
                       a0: data_command_select,
                       rd: read_strobe_pin,
                       wr: write_strobe_pin,
                       ps: parallel_serial_strap,
                       style: bus_style_strap,
                       data: data_in};

   always_comb begin
      // style strap consulted only once parallel operation is selected
      if (!core_reg.sync2.ps) begin
         mode = lcdh_pkg::LCDH_MODE_SERIAL;
      end else if (core_reg.sync2.style) begin
         mode = lcdh_pkg::LCDH_MODE_6800;
      end else begin
         mode = lcdh_pkg::LCDH_MODE_8080;
      end
   end

   assign cs_now = ~core_reg.sync2.cs_n & core_reg.sync2.cs_hi;
   assign cs_prev = ~core_reg.prev.cs_n & core_reg.prev.cs_hi;
   assign ser_evt = core_reg.tog2 ^ core_reg.tog3;

   always_comb begin
      rd_active = 1'b0;
      wr_evt = 1'b0;
      rd_evt = 1'b0;
      case (mode)
         lcdh_pkg::LCDH_MODE_8080: begin
            rd_active = ~core_reg.sync2.rd;
            // data and select are taken from the sample before the edge,
            // while the strobe was still low
            wr_evt = ~core_reg.prev.wr & core_reg.sync2.wr;
            rd_evt = ~core_reg.prev.rd & core_reg.sync2.rd;
         end
         lcdh_pkg::LCDH_MODE_6800: begin
            rd_active = core_reg.sync2.rd & core_reg.sync2.wr;
            wr_evt = core_reg.prev.rd & ~core_reg.sync2.rd &
                     ~core_reg.prev.wr;
            rd_evt = core_reg.prev.rd & ~core_reg.sync2.rd &
                     core_reg.prev.wr;
         end
         default: begin
            rd_active = 1'b0;
         end
      endcase
   end

   always_comb begin
      core_next = core_reg;
      core_next.sync1 = pins_raw;
      core_next.sync2 = core_reg.sync1;
      core_next.prev = core_reg.sync2;
      core_next.tog1 = ser_reg.tog;
      core_next.tog2 = core_reg.tog1;
      core_next.tog3 = core_reg.tog2;
      core_next.wr_valid = 1'b0;
      core_next.rd_valid = 1'b0;
      if (mode == lcdh_pkg::LCDH_MODE_SERIAL) begin
         if (ser_evt) begin
            core_next.wr_valid = 1'b1;
            core_next.wr_xfer = '{is_data: ser_reg.a0,
                                  value: ser_reg.byte_q};
         end
      end else if (cs_prev) begin
         if (wr_evt) begin
            core_next.wr_valid = 1'b1;
            core_next.wr_xfer = '{is_data: core_reg.prev.a0,
                                  value: core_reg.prev.data};
         end
         if (rd_evt) begin
            core_next.rd_valid = 1'b1;
            core_next.rd_is_data = core_reg.prev.a0;
         end
      end
      // the pad drives only for a selected parallel read
      if (cs_now && rd_active) begin
         core_next.doe = lcdh_pkg::OE_ALL;
         core_next.dout = core_reg.sync2.a0 ? disp_rd_data
                                            : status_byte;
      end else begin
         core_next.doe = lcdh_pkg::OE_NONE;
         core_next.dout = lcdh_pkg::BYTE_ZERO;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         core_reg <= '0;
      end else if (ce) begin
         core_reg <= core_next;
      end
   end

   assign data_out = core_reg.dout;
   assign data_oe = core_reg.doe;
   assign wr_valid = core_reg.wr_valid;
   assign wr_xfer = core_reg.wr_xfer;
   assign rd_valid = core_reg.rd_valid;
   assign rd_is_data = core_reg.rd_is_data;

   ////////////////////////////////////////////////////////////////////////
   // checks

   default clocking chk_cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   chk_desel_float: assert property (
      ce && !cs_now |=> data_oe == lcdh_pkg::OE_NONE)
      else $error("data pins driven while deselected");

   chk_serial_float: assert property (
      ce && mode == lcdh_pkg::LCDH_MODE_SERIAL
      |=> data_oe == lcdh_pkg::OE_NONE)
      else $error("data pins driven in serial mode");

   chk_serial_noread: assert property (
      ce && mode == lcdh_pkg::LCDH_MODE_SERIAL |=> !rd_valid)
      else $error("read reported in serial mode");

   chk_wr_rise_8080: assert property (
      ce && mode == lcdh_pkg::LCDH_MODE_8080 && cs_prev && wr_evt
      |=> wr_valid && wr_xfer.value == $past(core_reg.prev.data)
          && wr_xfer.is_data == $past(core_reg.prev.a0))
      else $error("8080 write not taken at strobe rise");

   chk_wr_fall_6800: assert property (
      ce && mode == lcdh_pkg::LCDH_MODE_6800 && cs_prev
      && core_reg.prev.rd && !core_reg.sync2.rd && !core_reg.prev.wr
      |=> wr_valid)
      else $error("6800 write not taken at enable fall");

   chk_no_wr_unsel: assert property (
      ce && mode != lcdh_pkg::LCDH_MODE_SERIAL && !cs_prev |=> !wr_valid)
      else $error("write taken while deselected");

   chk_read_source: assert property (
      ce && cs_now && rd_active
      |=> data_oe == lcdh_pkg::OE_ALL
          && data_out == ($past(core_reg.sync2.a0) ? $past(disp_rd_data)
                                                   : $past(status_byte)))
      else $error("read data from wrong source");

   chk_serial_byte: assert property (
      ce && mode == lcdh_pkg::LCDH_MODE_SERIAL && ser_evt
      |=> wr_valid && wr_xfer.is_data == $past(ser_reg.a0)
          && wr_xfer.value == $past(ser_reg.byte_q))
      else $error("serial byte not handed over");

   chk_style_ignored: assert property (
      !core_reg.sync2.ps |-> mode == lcdh_pkg::LCDH_MODE_SERIAL)
      else $error("style strap acted in serial mode");

   chk_rd_end_8080: assert property (
      ce && mode == lcdh_pkg::LCDH_MODE_8080 && cs_prev && rd_evt
      |=> rd_valid && rd_is_data == $past(core_reg.prev.a0))
      else $error("8080 read end not reported");

   chk_rd_end_6800: assert property (
      ce && mode == lcdh_pkg::LCDH_MODE_6800 && cs_prev
      && core_reg.prev.rd && !core_reg.sync2.rd && core_reg.prev.wr
      |=> rd_valid && rd_is_data == $past(core_reg.prev.a0))
      else $error("6800 read end not reported");

   chk_no_rd_unsel: assert property (
      ce && !cs_prev |=> !rd_valid)
      else $error("read reported while deselected");

   // an idle read strobe must leave the pins to the host
   chk_idle_float_8080: assert property (
      ce && mode == lcdh_pkg::LCDH_MODE_8080 && core_reg.sync2.rd
      |=> data_oe == lcdh_pkg::OE_NONE)
      else $error("data pins driven without read strobe");

   chk_write_float_6800: assert property (
      ce && mode == lcdh_pkg::LCDH_MODE_6800 && !core_reg.sync2.wr
      |=> data_oe == lcdh_pkg::OE_NONE)
      else $error("data pins driven during a 6800 write");

   chk_wr_single_pulse: assert property (
      ce && wr_valid |=> !wr_valid)
      else $error("write pulse longer than one cycle");

   // the serial clock may stop while deselected, so this one runs on it
   chk_ser_count_clear: assert property (
      @(posedge serial_clk) disable iff (!rst_n)
      ser_sel_n |-> bit_cnt_reg == lcdh_pkg::BIT_ZERO)
      else $error("serial bit count kept while deselected");

   cov_write_6800: cover property (
      mode == lcdh_pkg::LCDH_MODE_6800 ##1 wr_valid);
   cov_write_8080: cover property (
      mode == lcdh_pkg::LCDH_MODE_8080 ##1 wr_valid);
   cov_read_6800: cover property (
      mode == lcdh_pkg::LCDH_MODE_6800 && rd_active && cs_now ##1 rd_valid);
   cov_serial_cmd: cover property (
      mode == lcdh_pkg::LCDH_MODE_SERIAL ##1 wr_valid && !wr_xfer.is_data);
   cov_status_read: cover property (
      cs_now && rd_active && !core_reg.sync2.a0);

endmodule : lcdh_host_port

/* hdl/lcdh_pkg.sv */
// shared constants and types for the display host port
package lcdh_pkg;

   localparam int DATA_W = 8;
   localparam int SI_BIT = 7;
   localparam logic [2:0] BIT_ZERO = 3'h0;
   localparam logic [2:0] BIT_ONE = 3'h1;
   localparam logic [2:0] BIT_LAST = 3'h7;
   localparam logic [7:0] BYTE_ZERO = 8'h00;
   localparam logic [7:0] OE_ALL = 8'hFF;
   localparam logic [7:0] OE_NONE = 8'h00;

   typedef enum logic [1:0] {
      LCDH_MODE_SERIAL = 2'b00,
      LCDH_MODE_8080 = 2'b01,
      LCDH_MODE_6800 = 2'b10
   } lcdh_mode_t;

   // one transfer handed to the display core
   typedef struct packed {
      logic is_data;
      logic [7:0] value;
   } lcdh_xfer_t;

   // host pins as sampled in the core clock domain
   typedef struct packed {
      logic cs_n;
      logic cs_hi;
      logic a0;
      logic rd;
      logic wr;
      logic ps;
      logic style;
      logic [7:0] data;
   } lcdh_pins_t;

   // all state of the core clock domain
   typedef struct packed {
      lcdh_pins_t sync1;
      lcdh_pins_t sync2;
      lcdh_pins_t prev;
      logic tog1;
      logic tog2;
      logic tog3;
      logic wr_valid;
      lcdh_xfer_t wr_xfer;
      logic rd_valid;
      logic rd_is_data;
      logic [7:0] dout;
      logic [7:0] doe;
   } lcdh_core_t;

   // state of the serial clock domain
   typedef struct packed {
      logic [7:0] shift;
      logic [7:0] byte_q;
      logic a0;
      logic tog;
   } lcdh_ser_t;

endpackage : lcdh_pkg

/* sim/lcdh_host_model.sv */
// host processor model driving the display port pins
`timescale 1ns/1ns
module lcdh_host_model (
   input wire logic clk,
   input wire logic style,
   output logic rd_pin,
   output logic wr_pin,
   output logic a0,
   output logic sclk,
   output logic host_oe,
   output logic [7:0] dq,
   input wire logic [7:0] bus
);
   logic [7:0] drv;
   logic [7:0] flt;
   initial begin
      rd_pin = 1'h1;
      wr_pin = 1'h1;
      a0 = 1'h0;
      sclk = 1'h0;
      host_oe = 1'h0;
      drv = 8'h00;
      flt = 8'h00;
   end
   // the tasks own drv and this process owns flt, so no edge sees two
   // writers of the same bus value
   assign dq = host_oe ? drv : flt;
   // a released bus must not keep showing the last byte
   always @(posedge clk) begin
      flt <= ~dq;
   end
   ////////////////////////////////////////////////////////////////////////
   // one parallel cycle; strobe levels follow the selected bus style
   task automatic cyc(input logic rd_op, input logic a0v,
                      input logic [7:0] d, output logic [7:0] q);
      @(posedge clk);
      rd_pin <= ~style;
      wr_pin <= rd_op;
      a0 <= a0v;
      drv <= d;
      host_oe <= ~rd_op;
      @(posedge clk);
      rd_pin <= style | ~rd_op;
      repeat (40) @(posedge clk);
      q = bus;
      rd_pin <= ~style;
      repeat (3) @(posedge clk);
      wr_pin <= 1'h1;
      // data held past the strobe edge so the capture is clean
      repeat (4) @(posedge clk);
      host_oe <= 1'h0;
      repeat (25) @(posedge clk);
   endtask : cyc
   // n serial bits, msb first; strobe pins left untouched
   task automatic ser(input logic a0v, input logic [7:0] b, input int n);
      a0 = a0v;
      host_oe = 1'h1;
      for (int i = 7; i > 7 - n; i--) begin
         drv = {b[i], sclk, ~drv[5:0]};
         #63 sclk = 1'h1;
         #62 sclk = 1'h0;
      end
      host_oe = 1'h0;
   endtask : ser
endmodule : lcdh_host_model

/* sim/tb_lcd_module_host_interface.sv */
// self-checking bench for the display host port
`timescale 1ns/1ns
module tb_lcd_module_host_interface;
   logic clk, rst_n, ps, style, cs_n, cs_hi, rd_pin, wr_pin, a0, sclk;
   logic host_oe, wr_valid, rd_valid, rd_is_data, last_rd, ce;
   logic [7:0] dq, bus, data_out, data_oe, disp, stat, q;
   logic [10:0] r;
   lcdh_pkg::lcdh_xfer_t wr_xfer, last_wr;
   int err_total, n_checks, n_wr, n_drv, base, nd;
   // {style, read, select, byte}
   logic [10:0] rows [8] = '{11'h0FF, 11'h100, 11'h2A5, 11'h35A,
                             11'h481, 11'h57E, 11'h63C, 11'h7C3};
   assign bus = (data_oe === 8'hFF) ? data_out : dq;
   lcdh_host_port lcdh_host_port_i (.clk(clk), .rst_n(rst_n), .ce(ce),
      .serial_clk(sclk), .parallel_serial_strap(ps),
      .bus_style_strap(style), .chip_select_low_active_n(cs_n),
      .chip_select_high_active(cs_hi), .data_command_select(a0),
      .read_strobe_pin(rd_pin), .write_strobe_pin(wr_pin), .data_in(bus),
      .data_out(data_out), .data_oe(data_oe), .disp_rd_data(disp),
      .status_byte(stat), .wr_valid(wr_valid), .wr_xfer(wr_xfer),
      .rd_valid(rd_valid), .rd_is_data(rd_is_data));
   lcdh_host_model lcdh_host_model_i (.clk(clk), .style(style),
      .rd_pin(rd_pin), .wr_pin(wr_pin), .a0(a0), .sclk(sclk),
      .host_oe(host_oe), .dq(dq), .bus(bus));
   always @(posedge clk) begin
      if (wr_valid === 1'h1) begin
         n_wr <= n_wr + 1;
         last_wr <= wr_xfer;
      end
      if (rd_valid === 1'h1) begin
         last_rd <= rd_is_data;
      end
      if (data_oe !== 8'h00) begin
         n_drv <= n_drv + 1;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input string what, input logic [9:0] exp,
                      input logic [9:0] got);
      n_checks++;
      if (got !== exp) begin
         err_total++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic sbyte(input logic a0v, input logic [7:0] b);
      base = n_wr;
      lcdh_host_model_i.ser(a0v, b, 8);
      repeat (8) @(posedge clk);
      chk("serial byte", {1'h1, a0v, b},
          {n_wr == base + 1, last_wr});
   endtask : sbyte
   task automatic summarize;
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : summarize
   initial begin
      clk = 1'h0;
      forever #2 clk = ~clk;
   end
   initial begin
      #50000;
      err_total++;
      summarize();
   end
   initial begin
      {rst_n, ps, style, cs_n, cs_hi, ce, disp, stat} = {6'h13, 16'h0000};
      repeat (10) @(posedge clk);
      rst_n <= 1'h1;
      foreach (rows[i]) begin
         r = rows[i];
         @(posedge clk);
         style <= r[10];
         disp <= r[8] ? r[7:0] : ~r[7:0];
         stat <= r[8] ? ~r[7:0] : r[7:0];
         base = n_wr;
         lcdh_host_model_i.cyc(r[9], r[8], r[7:0], q);
         if (r[9]) begin
            chk("read byte", {2'h0, r[7:0]},
                {2'h0, q});
            chk("read kind", {9'h000, r[8]}, {9'h000, last_rd});
         end else begin
            chk("write", {1'h1, r[8:0]},
                {n_wr == base + 1, last_wr});
         end
         $display("row %0d done", i);
      end
      base = n_wr;
      nd = n_drv;
      for (int k = 0; k < 2; k++) begin
         @(posedge clk);
         cs_n <= ~k[0];
         cs_hi <= ~k[0];
         lcdh_host_model_i.cyc(1'h0, 1'h1, 8'h66, q);
         lcdh_host_model_i.cyc(1'h1, 1'h1, 8'h66, q);
      end
      chk("deselect writes", 10'h000, 10'(n_wr - base));
      chk("deselect drive", 10'h000, 10'(n_drv - nd));
      $display("deselect test done");
      @(posedge clk);
      {cs_n, cs_hi, ps} <= 3'h2;
      repeat (10) @(posedge clk);
      nd = n_drv;
      sbyte(1'h1, 8'h96);
      style <= 1'h0;
      sbyte(1'h0, 8'h3C);
      lcdh_host_model_i.ser(1'h1, 8'hE0, 3);
      @(posedge clk);
      cs_n <= 1'h1;
      repeat (4) @(posedge clk);
      cs_n <= 1'h0;
      repeat (4) @(posedge clk);
      sbyte(1'h0, 8'h47);
      chk("serial drive", 10'h000, 10'(n_drv - nd));
      $display("serial test done");
      @(posedge clk);
      rst_n <= 1'h0;
      repeat (3) @(posedge clk);
      chk("reset flags", 10'h000, {wr_valid, rd_valid, data_oe});
      chk("reset xfer", 10'h000, {1'h0, wr_xfer});
      $display("reset test done");
      @(posedge clk);
      {ps, style, ce} <= 3'h4;
      repeat (7) @(posedge clk);
      rst_n <= 1'h1;
      base = n_wr;
      lcdh_host_model_i.cyc(1'h0, 1'h0, 8'hA5, q);
      chk("frozen write", 10'h000, 10'(n_wr - base));
      @(posedge clk);
      ce <= 1'h1;
      repeat (10) @(posedge clk);
      lcdh_host_model_i.cyc(1'h0, 1'h1, 8'h5A, q);
      chk("write after reset", 10'h35A,
          {n_wr == base + 1, last_wr});
      $display("restart test done");
      summarize();
   end
endmodule : tb_lcd_module_host_interface
